/* inc/bcm_pkg.sv */
package bcm_pkg;
   localparam int ADDR_W = 12;
   localparam logic [11:0] PNP_ADDR_PORT = 12'h279;
   localparam logic [11:0] PAIR1_ADDR = 12'h3f0;
   localparam logic [11:0] PAIR1_DATA = 12'h3f1;
   localparam logic [11:0] PAIR2_ADDR = 12'h3bd;
   localparam logic [11:0] PAIR2_DATA = 12'h3bf;
   localparam logic [11:0] PAIR3_ADDR = 12'h370;
   localparam logic [11:0] PAIR3_DATA = 12'h371;
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_PAIR1 = 2'h1;
   localparam logic [1:0] SEL_PAIR2 = 2'h2;
   localparam logic [1:0] SEL_PAIR3 = 2'h3;
   localparam logic [7:0] HDR_SEL_A = 8'h55;
   localparam logic [7:0] HDR_SEL_B = 8'haa;
   localparam logic [1:0] HDR_LAST = 2'h3;
   localparam logic [1:0] HDR_THIRD = 2'h2;
   localparam logic [7:0] KEY_INIT = 8'h6a;
   localparam logic [5:0] KEY_LEN = 6'h20;
   localparam logic [7:0] IDX_CTRL = 8'h02;
   localparam logic [7:0] IDX_UNIT = 8'h07;
   localparam logic [7:0] IDX_MULTI = 8'h22;
   localparam logic [7:0] IDX_ENABLE = 8'h23;
   localparam int CTRL_EXIT_BIT = 1;
   localparam int MULTI_LOW_BIT = 4;
   localparam int MULTI_HIGH_BIT = 5;
   localparam logic [7:0] UNIT_RST = 8'h00;
   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [7:0] INDEX_RST = 8'h00;
   localparam logic [1:0] STRAP_RST = 2'h0;
   typedef enum logic [1:0] {
      ST_WAIT = 2'b00,
      ST_KEY = 2'b01,
      ST_UNLOCK = 2'b10,
      ST_CFG = 2'b11
   } bcm_state_t;
endpackage

/* inc/bcm_key_if.sv */
`timescale 1ns/1ns
interface bcm_key_if;
   logic step;
   logic reload;
   logic [7:0] expected;
   logic done;
   modport ctrl (output step, output reload, input expected, input done);
   modport gen (input step, input reload, output expected, output done);
endinterface

/* rtl/bcm_key_key_shift_register.sv */
`timescale 1ns/1ns
module bcm_key_key_shift_register (
   input wire logic clk,
   input wire logic rst,
   bcm_key_if.gen key
);
   logic [7:0] key_shift_register_r;
   logic [5:0] count_r;
   wire [7:0] key_shift_register_next = {key_shift_register_r[0] ^ key_shift_register_r[1], key_shift_register_r[7:1]};

   assign key.expected = key_shift_register_r;
   assign key.done = (count_r == bcm_pkg::KEY_LEN - 6'h1);

   always_ff @(posedge clk) begin
      if (rst || key.reload) begin
         key_shift_register_r <= bcm_pkg::KEY_INIT;
         count_r <= 6'h00;
      end else if (key.step) begin
         key_shift_register_r <= key_shift_register_next;
         count_r <= count_r + 6'h01;
      end
   end

   property p_key_shift_register_reload;
      @(posedge clk) disable iff (rst) key.reload |=> key_shift_register_r == 8'h6a && count_r == 6'h00;
   endproperty
   a_key_shift_register_reload: assert property (p_key_shift_register_reload) else $error("key register not reloaded");

   property p_key_shift_register_step;
      @(posedge clk) disable iff (rst)
         key.step && !key.reload |=> key_shift_register_r == {$past(key_shift_register_r[0]) ^ $past(key_shift_register_r[1]), $past(key_shift_register_r[7:1])};
   endproperty
   a_key_shift_register_step: assert property (p_key_shift_register_step) else $error("key register stepped wrongly");
endmodule

/* rtl/bcm_entry_top.sv */
`timescale 1ns/1ns
// Overview of operation
// - Strap pins are inputs during reset
// - Straps latched as reset falls
// - Reset leaves normal mode, units disabled
// - Latched straps feed serial identifier bits
// - Index 22h bits must match inverted straps
// - Entry needs 32 checked key writes
// - Header bytes pick the port pair
// - Trailing 32 bytes follow the header
// - Shift register makes expected bytes
// - Mode opens all configuration registers
// - Index 07h selects the logical unit
// - Some registers settle only after exit
// - Bit 1 of index 02h exits
module bcm_entry_top #(
   parameter logic [7:0] KEY_ID0 = 8'h5a, // Arbitrary identifying byte
   parameter logic [7:0] KEY_ID1 = 8'h3c // Arbitrary identifying byte
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [bcm_pkg::ADDR_W-1:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic aen,
   output logic [7:0] host_rd_data,
   output logic host_rd_valid,
   input wire logic cfg_strap_low,
   input wire logic cfg_strap_high,
   input wire logic uart_terminal_ready_n,
   input wire logic uart_request_send_n,
   output logic port1_terminal_ready_n_o,
   output logic port1_terminal_ready_n_oe,
   output logic port1_request_send_n_o,
   output logic port1_request_send_n_oe,
   output logic [1:0] pnp_serial_lsb,
   output logic board_config_mode,
   output logic [1:0] port_pair_sel,
   output logic [7:0] logical_unit_number,
   output logic [7:0] unit_enable,
   output logic [7:0] reg_index,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rd_data,
   output logic settled
);
   bcm_pkg::bcm_state_t state_r, state_nxt;
   logic [1:0] hdr_cnt_r, hdr_cnt_nxt;
   logic [7:0] hdr3_r, hdr3_nxt;
   logic [1:0] sel_r, sel_nxt;
   logic [7:0] index_r, index_nxt;
   logic [7:0] unit_r, unit_nxt;
   logic [7:0] enable_r, enable_nxt;
   logic settled_r, settled_nxt;
   logic [1:0] strap_r;
   logic reg_wr_r, reg_wr_nxt;
   logic reg_rd_r, reg_rd_nxt;
   logic [7:0] reg_wdata_r, reg_wdata_nxt;
   logic [7:0] rd_data_r;
   logic rd_valid_r, rd_valid_nxt;

   bcm_key_if key ();

   bcm_key_key_shift_register u_key_shift_register (
      .clk(clk),
      .rst(rst),
      .key(key)
   );

   // AEN high marks DMA cycles, which never count as configuration traffic
   wire wr_ok = ce & io_wr & ~aen;
   wire rd_ok = ce & io_rd & ~aen;
   wire [11:0] addr_port = (sel_r == bcm_pkg::SEL_PAIR1) ? bcm_pkg::PAIR1_ADDR :
                           (sel_r == bcm_pkg::SEL_PAIR2) ? bcm_pkg::PAIR2_ADDR :
                           bcm_pkg::PAIR3_ADDR;
   wire [11:0] data_port = (sel_r == bcm_pkg::SEL_PAIR1) ? bcm_pkg::PAIR1_DATA :
                           (sel_r == bcm_pkg::SEL_PAIR2) ? bcm_pkg::PAIR2_DATA :
                           bcm_pkg::PAIR3_DATA;
   wire pair_valid = (sel_r != bcm_pkg::SEL_NONE);
   wire at_pnp = (io_addr == bcm_pkg::PNP_ADDR_PORT);
   wire at_ap = pair_valid && (io_addr == addr_port);
   wire at_dp = pair_valid && (io_addr == data_port);
   wire dat_a = (io_wdata == bcm_pkg::HDR_SEL_A);
   wire dat_b = (io_wdata == bcm_pkg::HDR_SEL_B);
   wire h3_a = (hdr3_r == bcm_pkg::HDR_SEL_A);
   wire h3_b = (hdr3_r == bcm_pkg::HDR_SEL_B);
   wire hdr_ok = (hdr_cnt_r == 2'h0) ? (io_wdata == KEY_ID0) :
                 (hdr_cnt_r == 2'h1) ? (io_wdata == KEY_ID1) :
                 (hdr_cnt_r == bcm_pkg::HDR_THIRD) ? (dat_a | dat_b) :
                 ((h3_a & (dat_a | dat_b)) | (h3_b & dat_a));
   wire [1:0] sel_code = h3_b ? bcm_pkg::SEL_PAIR3 :
                         (dat_b ? bcm_pkg::SEL_PAIR2 : bcm_pkg::SEL_PAIR1);
   wire key_ok = at_ap && (io_wdata == key.expected);
   wire multi_ok = (io_wdata[bcm_pkg::MULTI_HIGH_BIT] == ~strap_r[1]) &&
                   (io_wdata[bcm_pkg::MULTI_LOW_BIT] == ~strap_r[0]);
   wire dp_wr = wr_ok & at_dp;
   wire ap_wr = wr_ok & at_ap;
   wire exit_req = dp_wr && (index_r == bcm_pkg::IDX_CTRL) && io_wdata[bcm_pkg::CTRL_EXIT_BIT];
   wire [7:0] local_rd = (index_r == bcm_pkg::IDX_UNIT) ? unit_r :
                         (index_r == bcm_pkg::IDX_ENABLE) ? enable_r : reg_rd_data;

   always_comb begin
      state_nxt = state_r;
      hdr_cnt_nxt = hdr_cnt_r;
      hdr3_nxt = hdr3_r;
      sel_nxt = sel_r;
      index_nxt = index_r;
      unit_nxt = unit_r;
      enable_nxt = enable_r;
      settled_nxt = settled_r;
      reg_wr_nxt = 1'b0;
      reg_rd_nxt = 1'b0;
      reg_wdata_nxt = reg_wdata_r;
      rd_valid_nxt = 1'b0;
      key.step = 1'b0;
      key.reload = 1'b0;
      case (state_r)
         bcm_pkg::ST_WAIT: begin
            if (wr_ok && at_pnp) begin
               if (hdr_ok) begin
                  hdr_cnt_nxt = hdr_cnt_r + 2'h1;
                  if (hdr_cnt_r == bcm_pkg::HDR_THIRD) begin
                     hdr3_nxt = io_wdata;
                  end
                  if (hdr_cnt_r == bcm_pkg::HDR_LAST) begin
                     sel_nxt = sel_code;
                     state_nxt = bcm_pkg::ST_KEY;
                  end
               end else begin
                  hdr_cnt_nxt = 2'h0;
                  sel_nxt = bcm_pkg::SEL_NONE;
                  key.reload = 1'b1;
               end
            end
         end
         bcm_pkg::ST_KEY: begin
            if (wr_ok && key_ok) begin
               if (key.done) begin
                  key.reload = 1'b1;
                  state_nxt = bcm_pkg::ST_UNLOCK;
               end else begin
                  key.step = 1'b1;
               end
            end else if (wr_ok || rd_ok) begin
               key.reload = 1'b1;
               hdr_cnt_nxt = 2'h0;
               sel_nxt = bcm_pkg::SEL_NONE;
               state_nxt = bcm_pkg::ST_WAIT;
            end
         end
         bcm_pkg::ST_UNLOCK: begin
            if (ap_wr) begin
               index_nxt = io_wdata;
            end else if (dp_wr) begin
               if ((index_r == bcm_pkg::IDX_MULTI) && multi_ok) begin
                  state_nxt = bcm_pkg::ST_CFG;
                  settled_nxt = 1'b0;
               end else begin
                  hdr_cnt_nxt = 2'h0;
                  sel_nxt = bcm_pkg::SEL_NONE;
                  state_nxt = bcm_pkg::ST_WAIT;
               end
            end
         end
         bcm_pkg::ST_CFG: begin
            if (ap_wr) begin
               index_nxt = io_wdata;
            end else if (exit_req) begin
               hdr_cnt_nxt = 2'h0;
               sel_nxt = bcm_pkg::SEL_NONE;
               settled_nxt = 1'b1;
               state_nxt = bcm_pkg::ST_WAIT;
            end else if (dp_wr && (index_r == bcm_pkg::IDX_UNIT)) begin
               unit_nxt = io_wdata;
            end else if (dp_wr && (index_r == bcm_pkg::IDX_ENABLE)) begin
               enable_nxt = io_wdata;
            end else if (dp_wr) begin
               reg_wr_nxt = 1'b1;
               reg_wdata_nxt = io_wdata;
            end else if (rd_ok && at_dp) begin
               reg_rd_nxt = 1'b1;
               rd_valid_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = bcm_pkg::ST_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) strap_r <= {cfg_strap_high, cfg_strap_low};
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= bcm_pkg::ST_WAIT;
         hdr_cnt_r <= 2'h0;
         hdr3_r <= 8'h00;
         sel_r <= bcm_pkg::SEL_NONE;
         index_r <= bcm_pkg::INDEX_RST;
         unit_r <= bcm_pkg::UNIT_RST;
         enable_r <= bcm_pkg::ENABLE_RST;
         settled_r <= 1'b1;
         reg_wdata_r <= 8'h00;
         rd_data_r <= 8'h00;
      end else if (ce) begin
         state_r <= state_nxt;
         hdr_cnt_r <= hdr_cnt_nxt;
         hdr3_r <= hdr3_nxt;
         sel_r <= sel_nxt;
         index_r <= index_nxt;
         unit_r <= unit_nxt;
         enable_r <= enable_nxt;
         settled_r <= settled_nxt;
         reg_wdata_r <= reg_wdata_nxt;
         if (rd_valid_nxt) begin
            rd_data_r <= local_rd;
         end
      end
   end

   // Pulses drop even with ce low so a stalled cycle never repeats an access
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_wr_r <= 1'b0;
         reg_rd_r <= 1'b0;
         rd_valid_r <= 1'b0;
      end else begin
         reg_wr_r <= reg_wr_nxt;
         reg_rd_r <= reg_rd_nxt;
         rd_valid_r <= rd_valid_nxt;
      end
   end

   assign port1_terminal_ready_n_oe = ~rst;
   assign port1_request_send_n_oe = ~rst;
   assign port1_terminal_ready_n_o = uart_terminal_ready_n;
   assign port1_request_send_n_o = uart_request_send_n;
   assign pnp_serial_lsb = strap_r;
   assign board_config_mode = (state_r == bcm_pkg::ST_CFG);
   assign port_pair_sel = sel_r;
   assign logical_unit_number = unit_r;
   assign unit_enable = enable_r;
   assign reg_index = index_r;
   assign reg_wdata = reg_wdata_r;
   assign reg_wr = reg_wr_r;
   assign reg_rd = reg_rd_r;
   assign host_rd_data = rd_data_r;
   assign host_rd_valid = rd_valid_r;
   assign settled = settled_r;

   sequence s_exit_write;
      state_r == bcm_pkg::ST_CFG && ce && exit_req;
   endsequence
   sequence s_back_waiting;
      state_r == bcm_pkg::ST_WAIT && settled_r && sel_r == 2'h0;
   endsequence
   property p_pins_in_reset;
      @(posedge clk) rst |-> !port1_terminal_ready_n_oe && !port1_request_send_n_oe;
   endproperty
   a_pins_in_reset: assert property (p_pins_in_reset) else $error("strap pins driven in reset");
   property p_strap_hold;
      @(posedge clk) !rst && !$past(rst) |-> $stable(pnp_serial_lsb);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap latch moved");
   property p_reset_normal;
      @(posedge clk) $past(rst) && !rst |->
         !board_config_mode && unit_enable == 8'h00 && state_r == bcm_pkg::ST_WAIT;
   endproperty
   a_reset_normal: assert property (p_reset_normal) else $error("not normal after reset");
   property p_strap_gate;
      @(posedge clk) disable iff (rst)
         state_r == bcm_pkg::ST_UNLOCK && dp_wr && !multi_ok |=> !board_config_mode;
   endproperty
   a_strap_gate: assert property (p_strap_gate) else $error("mode entered without strap match");
   property p_key_fail;
      @(posedge clk) disable iff (rst)
         state_r == bcm_pkg::ST_KEY && wr_ok && !key_ok |=> state_r == bcm_pkg::ST_WAIT;
   endproperty
   a_key_fail: assert property (p_key_fail) else $error("bad key byte accepted");
   property p_key_has_pair;
      @(posedge clk) disable iff (rst) state_r == bcm_pkg::ST_KEY |-> sel_r != 2'h0;
   endproperty
   a_key_has_pair: assert property (p_key_has_pair) else $error("key phase without port pair");
   property p_hdr_fail;
      @(posedge clk) disable iff (rst)
         state_r == bcm_pkg::ST_WAIT && wr_ok && at_pnp && !hdr_ok |=>
            sel_r == 2'h0 && hdr_cnt_r == 2'h0 && key.expected == 8'h6a;
   endproperty
   a_hdr_fail: assert property (p_hdr_fail) else $error("bad header not restarted");
   property p_exit;
      @(posedge clk) disable iff (rst) s_exit_write |=> s_back_waiting;
   endproperty
   a_exit: assert property (p_exit) else $error("exit write did not leave mode");
   property p_unit_write;
      @(posedge clk) disable iff (rst)
         state_r == bcm_pkg::ST_CFG && dp_wr && index_r == 8'h07 |=>
            logical_unit_number == $past(io_wdata);
   endproperty
   a_unit_write: assert property (p_unit_write) else $error("unit number not stored");
   property p_outside_quiet;
      @(posedge clk) disable iff (rst)
         !board_config_mode |=> !reg_wr && !reg_rd && !host_rd_valid;
   endproperty
   a_outside_quiet: assert property (p_outside_quiet) else $error("access decoded outside mode");
   property p_unsettled;
      @(posedge clk) disable iff (rst) board_config_mode |-> !settled;
   endproperty
   a_unsettled: assert property (p_unsettled) else $error("settled flag high in mode");
endmodule

/* bench/bcm_host_model.sv */
`timescale 1ns/1ns
module bcm_host_model (
   input wire logic clk,
   output logic [bcm_pkg::ADDR_W-1:0] io_addr,
   output logic [7:0] io_wdata,
   output logic io_wr,
   output logic io_rd,
   output logic aen
);
   initial begin
      io_addr = 12'h000;
      io_wdata = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      aen = 1'b0;
   end
   // one access every two cycles, nothing interleaved
   task automatic access(input logic [11:0] a, input logic [7:0] d, input logic rd,
                         input logic dma);
      @(posedge clk);
      #1;
      io_addr = a;
      io_wdata = d;
      io_wr = ~rd;
      io_rd = rd;
      aen = dma;
      @(posedge clk);
      #1;
      io_wr = 1'b0;
      io_rd = 1'b0;
      aen = 1'b0;
      // Released bus shows a changed pattern so stale values never match
      io_addr = ~a;
      io_wdata = ~d;
   endtask
endmodule

/* bench/bcm_entry_top_tb.sv */
`timescale 1ns/1ns
module bcm_entry_top_tb;
   localparam logic [7:0] ID0 = 8'h5a; // Arbitrary identifying byte
   localparam logic [7:0] ID1 = 8'h3c; // Arbitrary identifying byte
   localparam logic [11:0] PNP = bcm_pkg::PNP_ADDR_PORT;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic strap_lo, strap_hi, s_lo, s_hi, uart_tr_n, uart_rs_n, watch, ce;
   logic [7:0] rd_src, unit;
   logic [11:0] io_addr;
   logic [7:0] io_wdata, host_rd_data, logical_unit_number, unit_enable, reg_index, reg_wdata;
   logic io_wr, io_rd, aen, host_rd_valid, board_config_mode, reg_wr, reg_rd, settled;
   logic tr_o, tr_oe, rs_o, rs_oe;
   logic [1:0] pnp_serial_lsb, port_pair_sel;
   logic [11:0] ap[4] = '{bcm_pkg::PAIR1_ADDR, bcm_pkg::PAIR1_ADDR, bcm_pkg::PAIR2_ADDR,
                          bcm_pkg::PAIR3_ADDR};
   logic [11:0] dp[4] = '{bcm_pkg::PAIR1_DATA, bcm_pkg::PAIR1_DATA, bcm_pkg::PAIR2_DATA,
                          bcm_pkg::PAIR3_DATA};
   logic [16:0] notes[$];
   int n_fail = 0;
   int samples_checked = 0;

   always #5 clk = ~clk;

   bcm_host_model bcm_host_model_inst (.clk(clk), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_wr(io_wr), .io_rd(io_rd), .aen(aen));

   bcm_entry_top #(.KEY_ID0(ID0), .KEY_ID1(ID1)) bcm_entry_top_inst (.clk(clk), .rst(rst),
      .ce(ce), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
      .aen(aen), .host_rd_data(host_rd_data), .host_rd_valid(host_rd_valid),
      .cfg_strap_low(strap_lo), .cfg_strap_high(strap_hi),
      .uart_terminal_ready_n(uart_tr_n), .uart_request_send_n(uart_rs_n),
      .port1_terminal_ready_n_o(tr_o), .port1_terminal_ready_n_oe(tr_oe),
      .port1_request_send_n_o(rs_o), .port1_request_send_n_oe(rs_oe),
      .pnp_serial_lsb(pnp_serial_lsb), .board_config_mode(board_config_mode),
      .port_pair_sel(port_pair_sel), .logical_unit_number(logical_unit_number),
      .unit_enable(unit_enable), .reg_index(reg_index), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(rd_src), .settled(settled));

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      bcm_host_model_inst.access(a, d, 1'b0, 1'b0);
   endtask

   task automatic rd(input logic [11:0] a);
      bcm_host_model_inst.access(a, 8'h00, 1'b1, 1'b0);
   endtask

   // Every forwarded pulse must match the oldest note; a pulse with no note is a fault
   always @(negedge clk) begin
      if (watch && (reg_wr === 1'b1 || host_rd_valid === 1'b1)) begin
         if (notes.size() == 0)
            check(1'b1, 1'b0, "unexpected forwarded access");
         else
            check({host_rd_valid, reg_index, host_rd_valid ? host_rd_data : reg_wdata},
                  notes.pop_front(), "forwarded access");
         if (host_rd_valid === 1'b1)
            check(reg_rd, 1'b1, "read strobe");
      end
   end

   task automatic enter(input logic [1:0] p, input int bad_at, input logic strap_ok);
      logic [7:0] k;
      logic ok;
      k = bcm_pkg::KEY_INIT;
      ok = p != 2'h0 && bad_at > 31 && strap_ok;
      wr(PNP, 8'h00);
      wr(PNP, 8'h00);
      wr(PNP, ID0);
      wr(PNP, ID1);
      // header picks the pair, bad pattern selects none
      wr(PNP, (p == 2'h3 || p == 2'h0) ? 8'haa : 8'h55);
      wr(PNP, (p == 2'h2 || p == 2'h0) ? 8'haa : 8'h55);
      for (int i = 0; i < 32; i++) begin
         // key bytes stepped from the shift register
         wr(ap[p], i == bad_at ? ~k : k);
         k = {k[0] ^ k[1], k[7:1]};
      end
      wr(ap[p], bcm_pkg::IDX_MULTI);
      wr(dp[p], {2'b00, ~s_hi ^ ~strap_ok, ~s_lo, 4'h0});
      repeat (2) @(posedge clk);
      #1;
      check(board_config_mode, ok, "mode entry");
      check(port_pair_sel, ok ? p : 2'h0, "pair select");
      $display("entry attempt pair %0d bad byte %0d done", p, bad_at);
   endtask

   task automatic session(input logic [1:0] p);
      logic [7:0] d;
      watch = 1'b1;
      check(settled, 1'b0, "settled in mode");
      unit = 8'($urandom);
      d = 8'($urandom);
      wr(ap[p], bcm_pkg::IDX_UNIT);
      wr(dp[p], unit);
      check(logical_unit_number, unit, "unit number");
      // Clock enable low must freeze the unit register
      ce = 1'b0;
      wr(dp[p], ~unit);
      ce = 1'b1;
      check(logical_unit_number, unit, "unit frozen by clock enable");
      notes.push_back({1'b1, bcm_pkg::IDX_UNIT, unit});
      rd(dp[p]);
      notes.push_back({1'b0, 8'h30, d});
      wr(ap[p], 8'h30);
      wr(dp[p], d);
      rd_src = 8'($urandom);
      notes.push_back({1'b1, 8'h30, rd_src});
      rd(dp[p]);
      wr(ap[p], bcm_pkg::IDX_ENABLE);
      wr(dp[p], d);
      check(unit_enable, d, "unit enable");
      // DMA cycles are not host accesses
      bcm_host_model_inst.access(dp[p], ~d, 1'b0, 1'b1);
      check(unit_enable, d, "dma write ignored");
      notes.push_back({1'b1, bcm_pkg::IDX_ENABLE, d});
      rd(dp[p]);
      wr(ap[p], bcm_pkg::IDX_CTRL);
      wr(dp[p], 8'h02);
      @(posedge clk);
      #1;
      check(board_config_mode, 1'b0, "exit");
      check(port_pair_sel, 2'h0, "exit pair");
      check(settled, 1'b1, "settled after exit");
      wr(dp[p], d);
      rd(dp[p]);
      repeat (3) @(posedge clk);
      check(17'(notes.size()), 17'h0, "notes left over");
      watch = 1'b0;
      $display("session on pair %0d done", p);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #200000;
      n_fail++;
      conclude();
   end

   initial begin
      void'($urandom(32'ha374));
      watch = 1'b0;
      ce = 1'b1;
      rd_src = 8'h00;
      strap_lo = 1'($urandom);
      strap_hi = 1'($urandom);
      uart_tr_n = 1'($urandom);
      uart_rs_n = 1'($urandom);
      repeat (6) @(posedge clk);
      check({tr_oe, rs_oe}, 2'b00, "pins released in reset");
      #1;
      rst = 1'b0;
      s_lo = strap_lo;
      s_hi = strap_hi;
      // Pins move after release; the latched copy must not
      strap_lo = ~strap_lo;
      strap_hi = ~strap_hi;
      @(posedge clk);
      #1;
      check(pnp_serial_lsb, {s_hi, s_lo}, "latched straps");
      check({tr_oe, rs_oe, tr_o, rs_o}, {2'b11, uart_tr_n, uart_rs_n}, "pins driven");
      check({board_config_mode, port_pair_sel, settled}, 4'h1, "reset mode");
      check(unit_enable, bcm_pkg::ENABLE_RST, "units disabled");
      $display("reset test done");
      enter(2'h0, 32, 1'b1);
      enter(2'h1, int'($urandom_range(31)), 1'b1);
      enter(2'h2, 32, 1'b0);
      for (int p = 1; p < 4; p++) begin
         enter(2'(p), 32, 1'b1);
         session(2'(p));
      end
      conclude();
   end
endmodule
